//--- logic/ipg_pkg.sv
`default_nettype none
package ipg_pkg;

   // Command opcodes accepted by the device.
   localparam logic [7:0] OP_IDLE = 8'he3;
   localparam logic [7:0] OP_IDLE_ALT = 8'h97;
   localparam logic [7:0] OP_IDLE_IMM = 8'he1;
   localparam logic [7:0] OP_IDLE_IMM_ALT = 8'h95;
   localparam logic [7:0] OP_INIT_PARAMS = 8'h91;

   // Status register bit positions.
   localparam int ST_BUSY = 7;
   localparam int ST_READY = 6;
   localparam int ST_FAULT = 5;
   localparam int ST_SEEK_DONE = 4;
   localparam int ST_ERROR = 0;
   // Error register bit position of the aborted command flag.
   localparam int ERR_ABORTED = 2;
   // Device/head register: head field width and the two bits that always read one.
   localparam int DH_HEAD_W = 4;
   localparam logic [7:0] DH_FIXED = 8'ha0;

   // Timing of the one-second tick that paces the standby timer.
   localparam int unsigned SECOND_NS = 1000000000;
   localparam int unsigned CLK_PERIOD_NS = 5;
   localparam int unsigned SEC_CYCLES = SECOND_NS / CLK_PERIOD_NS;

   // Standby interval encoding, in seconds.
   localparam logic [7:0] T_LINEAR_MAX = 8'hf0;
   localparam logic [7:0] T_HALFHR_MAX = 8'hfb;
   localparam logic [7:0] T_CODE_252 = 8'hfc;
   localparam logic [7:0] T_CODE_253 = 8'hfd;
   localparam logic [7:0] T_CODE_254 = 8'hfe;
   localparam logic [15:0] T_UNIT_SEC = 16'h0005;
   localparam logic [15:0] T_HALF_HOUR_SEC = 16'h0708;
   localparam logic [15:0] T_252_SEC = 16'h04ec;
   localparam logic [15:0] T_253_SEC = 16'h7080;
   localparam logic [15:0] T_254_SEC = 16'h04f6;
   localparam logic [15:0] T_255_SEC = 16'h04fb;

   // Controller register map, byte addresses on the AHB-Lite bus.
   localparam logic [7:0] REG_CMD = 8'h00;
   localparam logic [7:0] REG_STATUS = 8'h04;
   localparam logic [7:0] REG_INT_STATUS = 8'h08;
   localparam logic [7:0] REG_INT_CLEAR = 8'h0c;
   localparam logic [7:0] REG_INT_ENABLE = 8'h10;
   localparam int CMD_OP_LSB = 0;
   localparam int CMD_COUNT_LSB = 8;
   localparam int CMD_DH_LSB = 16;
   localparam int CMD_SOFT_RESET_BIT = 24;
   localparam int STAT_ERROR_LSB = 8;
   localparam int STAT_PENDING_BIT = 16;
   localparam int INT_DONE_BIT = 0;
   localparam int INT_ABORT_BIT = 1;
   localparam int INT_W = 2;
   localparam logic [1:0] INT_ENABLE_RST = 2'h0;

   typedef enum logic [1:0] {DEV_READY, DEV_SPINUP, DEV_FINISH} ipg_dev_state_t;
   typedef enum logic {HOST_IDLE, HOST_WAIT} ipg_host_state_t;

   // Seconds selected by a standby timer parameter; zero means disabled.
   function automatic logic [15:0] ipg_interval_sec(input logic [7:0] p);
      logic [15:0] r;
      r = 16'h0000;
      if (p == 8'h00) begin
         r = 16'h0000;
      end else if (p <= T_LINEAR_MAX) begin
         r = 16'(p) * T_UNIT_SEC;
      end else if (p <= T_HALFHR_MAX) begin
         r = 16'(p - T_LINEAR_MAX) * T_HALF_HOUR_SEC;
      end else if (p == T_CODE_252) begin
         r = T_252_SEC;
      end else if (p == T_CODE_253) begin
         r = T_253_SEC;
      end else if (p == T_CODE_254) begin
         r = T_254_SEC;
      end else begin
         r = T_255_SEC;
      end
      return r;
   endfunction

endpackage
`default_nettype wire

//--- logic/ipg_if.sv
`timescale 1ns/10ps
`default_nettype none
interface ipg_if;
   logic cmdWrite;
   logic [7:0] opcode;
   logic [7:0] sectorCount;
   logic [7:0] devHead;
   logic softReset;
   logic [7:0] status;
   logic [7:0] error;
   logic cmdDone;

   modport host (
      output cmdWrite, opcode, sectorCount, devHead, softReset,
      input status, error, cmdDone
   );
   modport device (
      input cmdWrite, opcode, sectorCount, devHead, softReset,
      output status, error, cmdDone
   );
endinterface
`default_nettype wire

//--- logic/ipg_device.sv
// Operation
// - Idle opcode E3h or 97h, same command
// - Idle: enter idle, load timer, count
// - Spin up unless spindle already turning
// - Idle mode accepts commands without delay
// - Zero parameter disables auto power-down
// - 1-240 times 5s; 241-251 half-hours
// - Codes 252 to 255 fixed intervals
// - Interval elapsed without access: enter standby
// - Host access reloads full interval
// - Idle immediate opcode E1h or 95h
// - Idle immediate keeps timer parameter
// - 91h sets sectors and heads minus one
// - Identify words 54-58 reflect geometry
// - Geometry kept unless soft reset reverts
// - Zero sectors per track means zero
// - Heads minus one ranges 0 to 15
// - Host keeps cylinder count within limit
`timescale 1ns/10ps
`default_nettype none
module ipg_device #(
   parameter int unsigned SEC_CYCLES = ipg_pkg::SEC_CYCLES,
   parameter logic [3:0] DEF_HEADS_M1 = 4'hf,
   parameter logic [7:0] DEF_SPT = 8'h3f,
   parameter logic [15:0] CYLINDERS = 16'h3fff
) (
   input wire logic clk, // 200 MHz clock
   input wire logic reset, // Asynchronous reset, high
   ipg_if.device link, // Task-file side toward the controller
   input wire logic spindleAtSpeed, // Spindle turning at operating speed
   input wire logic revertOnReset, // Soft reset restores default geometry
   output logic spinUpReq, // Request spindle spin-up
   output logic idleMode, // Drive in Idle mode
   output logic standbyMode, // Drive in Standby mode, spindle may stop
   output logic [15:0] idCylinders, // Identify word 54
   output logic [15:0] idHeads, // Identify word 55
   output logic [15:0] idSectors, // Identify word 56
   output logic [31:0] idCapacity // Identify words 57 and 58
);
   import ipg_pkg::*;

   typedef struct packed {
      ipg_dev_state_t state;
      logic [3:0] headsM1;
      logic [7:0] spt;
      logic [7:0] timerParam;
      logic [15:0] timerSec;
      logic [31:0] tickCnt;
      logic idleMode;
      logic standbyMode;
      logic spinUpReq;
      logic cmdDone;
      logic [7:0] status;
      logic [7:0] error;
      logic [15:0] idCylinders;
      logic [15:0] idHeads;
      logic [15:0] idSectors;
      logic [31:0] idCapacity;
   } ipg_dev_reg_t;

   // Status images: ready with seek complete when idle, busy alone while working.
   localparam logic [7:0] STATUS_IDLE = 8'h50;
   localparam logic [7:0] STATUS_BUSY = 8'h80;
   // Last count of the one-second prescaler, sized to its counter.
   localparam logic [31:0] TICK_LAST = 32'(SEC_CYCLES - 1);

   localparam ipg_dev_reg_t RESET_VAL = '{
      state: DEV_READY,
      headsM1: DEF_HEADS_M1,
      spt: DEF_SPT,
      timerParam: 8'h00,
      timerSec: 16'h0000,
      tickCnt: 32'h00000000,
      idleMode: 1'b1,
      standbyMode: 1'b0,
      spinUpReq: 1'b0,
      cmdDone: 1'b0,
      status: STATUS_IDLE,
      error: 8'h00,
      idCylinders: CYLINDERS,
      idHeads: 16'(DEF_HEADS_M1) + 16'h0001,
      idSectors: 16'(DEF_SPT),
      idCapacity: 32'(CYLINDERS) * (32'(DEF_HEADS_M1) + 32'h00000001) * 32'(DEF_SPT)
   };

   ipg_dev_reg_t q;
   ipg_dev_reg_t d;
   logic secTick;
   logic isIdle;
   logic isIdleImm;

   always_comb begin
      d = q;
      d.cmdDone = 1'b0;
      secTick = (q.tickCnt == TICK_LAST);
      d.tickCnt = secTick ? 32'h00000000 : q.tickCnt + 32'h00000001;
      // Idle and idle immediate each answer to a main and an alternate opcode.
      isIdle = (link.opcode == OP_IDLE) || (link.opcode == OP_IDLE_ALT);
      isIdleImm = (link.opcode == OP_IDLE_IMM) || (link.opcode == OP_IDLE_IMM_ALT);

      // The timer runs only while enabled and idle; expiry parks the drive in standby.
      if (q.timerParam != 8'h00 && q.idleMode) begin
         if (q.timerSec == 16'h0000) begin
            if (q.state == DEV_READY && !link.cmdWrite) begin
               d.idleMode = 1'b0;
               d.standbyMode = 1'b1;
            end
         end else if (secTick) begin
            d.timerSec = q.timerSec - 16'h0001;
         end
      end

      case (q.state)
         DEV_READY: begin
            // Idle mode adds no wake-up wait before a new command is taken.
            if (link.cmdWrite) begin
               d.status = STATUS_BUSY;
               d.error = 8'h00;
               d.timerSec = ipg_interval_sec(q.timerParam);
               d.tickCnt = 32'h00000000;
               if (isIdle || isIdleImm) begin
                  d.idleMode = 1'b1;
                  d.standbyMode = 1'b0;
                  // Idle immediate leaves the stored timer parameter as it was.
                  if (isIdle) begin
                     d.timerParam = link.sectorCount;
                     d.timerSec = ipg_interval_sec(link.sectorCount);
                  end
                  if (spindleAtSpeed) begin
                     d.state = DEV_FINISH;
                  end else begin
                     d.spinUpReq = 1'b1;
                     d.state = DEV_SPINUP;
                  end
               end else if (link.opcode == OP_INIT_PARAMS) begin
                  d.spt = link.sectorCount;
                  d.headsM1 = link.devHead[DH_HEAD_W-1:0];
                  d.state = DEV_FINISH;
               end else begin
                  d.error[ERR_ABORTED] = 1'b1;
                  d.state = DEV_FINISH;
               end
            end
         end
         DEV_SPINUP: begin
            // Busy stays up until the spindle reports operating speed.
            if (spindleAtSpeed) begin
               d.spinUpReq = 1'b0;
               d.state = DEV_FINISH;
            end
         end
         DEV_FINISH: begin
            // Completion shows ready and raises the error bit after an abort.
            d.status = STATUS_IDLE;
            d.status[ST_ERROR] = (q.error != 8'h00);
            d.cmdDone = 1'b1;
            d.state = DEV_READY;
         end
         default: begin
            d.state = DEV_READY;
         end
      endcase

      // Soft reset ends any command; geometry survives unless revert is selected.
      if (link.softReset) begin
         d.state = DEV_READY;
         d.spinUpReq = 1'b0;
         d.cmdDone = 1'b0;
         d.status = STATUS_IDLE;
         d.error = 8'h00;
         if (revertOnReset) begin
            d.headsM1 = DEF_HEADS_M1;
            d.spt = DEF_SPT;
         end
      end

      // Identify words follow the stored geometry one cycle later.
      d.idCylinders = CYLINDERS;
      d.idHeads = 16'(q.headsM1) + 16'h0001;
      d.idSectors = 16'(q.spt);
      d.idCapacity = 32'(CYLINDERS) * (32'(q.headsM1) + 32'h00000001) * 32'(q.spt);
   end

   // One register stage holds the whole device state.
   always_ff @(posedge clk or posedge reset) begin
      if (reset) begin
         q <= RESET_VAL;
      end else begin
         q <= d;
      end
   end

   // Every output is a flop of the state record.
   assign link.status = q.status;
   assign link.error = q.error;
   assign link.cmdDone = q.cmdDone;
   assign spinUpReq = q.spinUpReq;
   assign idleMode = q.idleMode;
   assign standbyMode = q.standbyMode;
   assign idCylinders = q.idCylinders;
   assign idHeads = q.idHeads;
   assign idSectors = q.idSectors;
   assign idCapacity = q.idCapacity;

endmodule // ipg_device
`default_nettype wire

//--- logic/ipg_host.sv
`timescale 1ns/10ps
`default_nettype none
module ipg_host (
   input wire logic clk, // 200 MHz clock
   input wire logic reset, // Asynchronous reset, high
   input wire logic hsel, // AHB-Lite slave select
   input wire logic [7:0] haddr, // AHB-Lite byte address
   input wire logic [1:0] htrans, // AHB-Lite transfer type
   input wire logic hwrite, // AHB-Lite write
   input wire logic [2:0] hsize, // AHB-Lite size, word only
   input wire logic hready, // AHB-Lite bus ready
   input wire logic [31:0] hwdata, // AHB-Lite write data
   output logic [31:0] hrdata, // AHB-Lite read data
   output logic hreadyout, // AHB-Lite slave ready
   output logic hresp, // AHB-Lite response, always OKAY
   output logic irq, // Level interrupt
   ipg_if.host link // Task-file side toward the drive
);
   import ipg_pkg::*;

   typedef struct packed {
      ipg_host_state_t state;
      logic wrPend;
      logic [7:0] wrAddr;
      logic [31:0] hrdata;
      logic hreadyout;
      logic hresp;
      logic cmdWrite;
      logic [7:0] opcode;
      logic [7:0] sectorCount;
      logic [7:0] devHead;
      logic softReset;
      logic [7:0] devStatus;
      logic [7:0] devError;
      logic [INT_W-1:0] intStat;
      logic [INT_W-1:0] intEn;
      logic irq;
   } ipg_host_reg_t;

   localparam ipg_host_reg_t RESET_VAL = '{
      state: HOST_IDLE, wrPend: 1'b0, wrAddr: 8'h00, hrdata: 32'h00000000,
      hreadyout: 1'b1, hresp: 1'b0, cmdWrite: 1'b0, opcode: 8'h00,
      sectorCount: 8'h00, devHead: DH_FIXED, softReset: 1'b0,
      devStatus: 8'h00, devError: 8'h00, intStat: '0, intEn: INT_ENABLE_RST, irq: 1'b0
   };

   ipg_host_reg_t q;
   ipg_host_reg_t d;
   logic [INT_W-1:0] intSet;
   logic [INT_W-1:0] intClr;

   always_comb begin
      d = q;
      d.cmdWrite = 1'b0;
      d.softReset = 1'b0;
      intSet = '0;
      intClr = '0;
      d.devStatus = link.status;
      d.devError = link.error;

      // Data phase of a write taken on the previous edge.
      d.wrPend = 1'b0;
      if (q.wrPend) begin
         case (q.wrAddr)
            REG_CMD: begin
               if (q.state == HOST_IDLE) begin
                  if (hwdata[CMD_SOFT_RESET_BIT]) begin
                     d.softReset = 1'b1;
                  end else begin
                     d.opcode = hwdata[CMD_OP_LSB +: 8];
                     d.sectorCount = hwdata[CMD_COUNT_LSB +: 8];
                     d.devHead = hwdata[CMD_DH_LSB +: 8] | DH_FIXED;
                     d.cmdWrite = 1'b1;
                     d.state = HOST_WAIT;
                  end
               end
            end
            REG_INT_CLEAR: intClr = hwdata[INT_W-1:0];
            REG_INT_ENABLE: d.intEn = hwdata[INT_W-1:0];
            default: d.intEn = q.intEn;
         endcase
      end

      if (q.state == HOST_WAIT && link.cmdDone) begin
         intSet[INT_DONE_BIT] = 1'b1;
         intSet[INT_ABORT_BIT] = link.error[ERR_ABORTED];
         d.state = HOST_IDLE;
      end
      if (q.state == HOST_WAIT && link.softReset) begin
         d.state = HOST_IDLE;
      end
      // A new event wins over a clear in the same cycle.
      d.intStat = (q.intStat & ~intClr) | intSet;
      d.irq = |(d.intStat & d.intEn);

      // Address phase: reads answer in the following data phase.
      d.hrdata = 32'h00000000;
      if (hsel && hready && htrans[1]) begin
         d.wrPend = hwrite;
         d.wrAddr = haddr;
         if (!hwrite) begin
            case (haddr)
               REG_STATUS: begin
                  d.hrdata[7:0] = q.devStatus;
                  d.hrdata[STAT_ERROR_LSB +: 8] = q.devError;
                  d.hrdata[STAT_PENDING_BIT] = (q.state == HOST_WAIT);
               end
               REG_INT_STATUS: d.hrdata[INT_W-1:0] = q.intStat;
               REG_INT_ENABLE: d.hrdata[INT_W-1:0] = q.intEn;
               default: d.hrdata = 32'h00000000;
            endcase
         end
      end
      d.hreadyout = 1'b1;
      d.hresp = 1'b0;
   end

   always_ff @(posedge clk or posedge reset) begin
      if (reset) begin
         q <= RESET_VAL;
      end else begin
         q <= d;
      end
   end

   assign hrdata = q.hrdata;
   assign hreadyout = q.hreadyout;
   assign hresp = q.hresp;
   assign irq = q.irq;
   assign link.cmdWrite = q.cmdWrite;
   assign link.opcode = q.opcode;
   assign link.sectorCount = q.sectorCount;
   assign link.devHead = q.devHead;
   assign link.softReset = q.softReset;

endmodule // ipg_host
`default_nettype wire

//--- sim/ipg_sva.sv
`timescale 1ns/10ps
`default_nettype none
module ipg_sva (
   input wire logic clk, // Clock
   input wire logic reset, // Reset
   input wire logic cmdWrite, // Command strobe
   input wire logic [7:0] opcode, // Opcode
   input wire logic [7:0] sectorCount, // Count
   input wire logic [7:0] devHead, // Device/head
   input wire logic softReset, // Soft reset
   input wire logic [7:0] status, // Status
   input wire logic [7:0] error, // Error
   input wire logic cmdDone // Done
);
   import ipg_pkg::*;
   logic [7:0] lastOp_q;
   logic known;
   // The opcode is remembered so that completion can be judged against it.
   always_ff @(posedge clk or posedge reset) begin
      if (reset) begin
         lastOp_q <= 8'h00;
      end else if (cmdWrite) begin
         lastOp_q <= opcode;
      end
   end
   assign known = lastOp_q inside {OP_IDLE, OP_IDLE_ALT, OP_IDLE_IMM, OP_IDLE_IMM_ALT, OP_INIT_PARAMS};
   default clocking cb @(posedge clk); endclocking
   default disable iff (reset);
   busy_on_take_a: assert property (cmdWrite |=> status == 8'h80)
      else $error("busy not shown");
   done_in_time_a: assert property (cmdWrite |-> ##[2:60] (cmdDone || softReset))
      else $error("no completion");
   good_done_a: assert property (cmdDone && known |-> error == 8'h00 && status == 8'h50)
      else $error("known opcode not accepted");
   abort_done_a: assert property (cmdDone && !known |-> error == 8'h04 && status == 8'h51)
      else $error("abort not reported");
   done_pulse_a: assert property (cmdDone |=> !cmdDone)
      else $error("done too long");
   no_cmd_busy_a: assert property (status[ST_BUSY] |-> !cmdWrite)
      else $error("command while busy");
   head_fixed_a: assert property (cmdWrite |-> devHead[7] && devHead[5])
      else $error("fixed bits low");
   reset_pulse_a: assert property (softReset |=> !softReset)
      else $error("soft reset too long");
   done_c: cover property (cmdDone && known);
   abort_c: cover property (cmdDone && !known);
   soft_c: cover property (softReset);
endmodule // ipg_sva
`default_nettype wire

//--- sim/idle_power_and_geometry_cmds_tb_top.sv
`timescale 1ns/10ps
`default_nettype none
module idle_power_and_geometry_cmds_tb_top;
   import ipg_pkg::*;
   localparam int SEC = 2;
   localparam logic [15:0] CYL = 16'h3fff;
   logic clk = 1'b0, reset = 1'b1, hsel = 1'b0, hwrite = 1'b0;
   logic [7:0] haddr = 8'h00;
   logic [1:0] htrans = 2'h0;
   logic [2:0] hsize = 3'h2;
   logic [31:0] hwdata = 32'h0, hrdata;
   logic hreadyout, hresp, irq, spinUpReq, idleMode, standbyMode;
   logic spindleAtSpeed = 1'b1, revertOnReset = 1'b0, spinSeen = 1'b0;
   logic [15:0] idCylinders, idHeads, idSectors;
   logic [31:0] idCapacity;
   int failures = 0, comparisons = 0, cycles = 0, tCmd = 0;
   logic [7:0] tp [7] = '{8'd1, 8'd240, 8'd241, 8'd252, 8'd253, 8'd254, 8'd255};
   int ts [7] = '{5, 1200, 1800, 21 * 60, 8 * 3600, 21 * 60 + 10, 21 * 60 + 15};
   logic [7:0] ops [6] = '{OP_IDLE, OP_IDLE_ALT, OP_IDLE_IMM, OP_IDLE_IMM_ALT, OP_INIT_PARAMS, 8'h42};
   ipg_if link();
   ipg_host ipg_host_inst (.clk(clk), .reset(reset), .hsel(hsel), .haddr(haddr), .htrans(htrans),
      .hwrite(hwrite), .hsize(hsize), .hready(hreadyout), .hwdata(hwdata), .hrdata(hrdata),
      .hreadyout(hreadyout), .hresp(hresp), .irq(irq), .link(link));
   ipg_device #(.SEC_CYCLES(SEC), .DEF_HEADS_M1(4'hf), .DEF_SPT(8'h3f), .CYLINDERS(CYL)) ipg_device_inst (
      .clk(clk), .reset(reset), .link(link), .spindleAtSpeed(spindleAtSpeed), .revertOnReset(revertOnReset),
      .spinUpReq(spinUpReq), .idleMode(idleMode), .standbyMode(standbyMode), .idCylinders(idCylinders),
      .idHeads(idHeads), .idSectors(idSectors), .idCapacity(idCapacity));
   ipg_sva ipg_sva_inst (.clk(clk), .reset(reset), .cmdWrite(link.cmdWrite), .opcode(link.opcode),
      .sectorCount(link.sectorCount), .devHead(link.devHead), .softReset(link.softReset),
      .status(link.status), .error(link.error), .cmdDone(link.cmdDone));
   always #2.5 clk = ~clk;
   // Cycle stamps let standby timing be measured from the command strobe itself.
   always @(posedge clk) begin
      cycles++;
      if (link.cmdWrite === 1'b1) begin
         tCmd = cycles;
      end
      if (spinUpReq === 1'b1) begin
         spinSeen = 1'b1;
      end
      if (cycles >= 90000) begin
         failures++;
         results();
      end
   end
   task automatic results();
      $display("comparisons %0d failures %0d", comparisons, failures);
      if (failures == 0 && comparisons > 0) begin
         $display("No errors found");
      end else begin
         $display("Errors were found");
      end
      $finish;
   endtask
   task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
      comparisons++;
      if (got !== exp) begin
         failures++;
         $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask
   task automatic cmpTime(input int got, input int lo, input int hi);
      comparisons++;
      if (got < lo || got > hi) begin
         failures++;
         $display("MISMATCH t=%0t got=%h exp=%h", $time, got, lo);
      end
   endtask
   task automatic ahb(input logic w, input logic [7:0] a, input logic [31:0] wd, output logic [31:0] rd);
      hsel <= 1'b1;
      htrans <= 2'h2;
      haddr <= a;
      hwrite <= w;
      do @(posedge clk); while (hreadyout !== 1'b1);
      htrans <= 2'h0;
      hwdata <= wd;
      do @(posedge clk); while (hreadyout !== 1'b1);
      rd = hrdata;
      cmp({31'h0, hresp}, 32'h0);
   endtask
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      logic [31:0] r;
      ahb(1'b1, a, d, r);
   endtask
   task automatic rd(input logic [7:0] a, input logic [31:0] e);
      logic [31:0] r;
      ahb(1'b0, a, 32'h0, r);
      cmp(r, e);
   endtask
   task automatic waitDone();
      logic [31:0] d;
      int n;
      n = 0;
      d = 32'h00010000;
      while (d[STAT_PENDING_BIT] !== 1'b0 && n < 50) begin
         ahb(1'b0, REG_STATUS, 32'h0, d);
         n++;
      end
      cmp({31'h0, d[STAT_PENDING_BIT]}, 32'h0);
   endtask
   task automatic cmdRun(input logic [31:0] w);
      wr(REG_CMD, w);
      waitDone();
   endtask
   task automatic waitStandby(input int e);
      int n;
      n = 0;
      while (standbyMode !== 1'b1 && n < e + 20) begin
         @(posedge clk);
         n++;
      end
      cmpTime(cycles - tCmd, e - 1, e + SEC + 3);
      cmp({31'h0, idleMode}, 32'h0);
   endtask
   task automatic geo(input logic [15:0] h, input logic [15:0] s);
      repeat (3) @(posedge clk);
      cmp({idHeads, idSectors}, {h, s});
      cmp(idCapacity, 32'(CYL) * 32'(h) * 32'(s));
   endtask
   initial begin
      repeat (16) @(posedge clk);
      reset <= 1'b0;
      @(posedge clk);
      rd(REG_STATUS, 32'h50);
      rd(REG_INT_ENABLE, 32'h0);
      wr(REG_STATUS, 32'hffffffff);
      wr(8'h14, 32'h5);
      rd(8'h14, 32'h0);
      rd(REG_STATUS, 32'h50);
      for (int i = 0; i < 6; i++) begin
         wr(REG_CMD, {8'h00, DH_FIXED, 8'h00, ops[i]});
         waitDone();
         rd(REG_STATUS, (i < 5) ? 32'h50 : 32'h451);
         cmp({31'h0, idleMode}, 32'h1);
      end
      rd(REG_INT_STATUS, 32'h3);
      cmp({31'h0, irq}, 32'h0);
      wr(REG_INT_ENABLE, 32'h1);
      rd(REG_INT_ENABLE, 32'h1);
      cmp({31'h0, irq}, 32'h1);
      wr(REG_INT_CLEAR, 32'h1);
      rd(REG_INT_STATUS, 32'h2);
      cmp({31'h0, irq}, 32'h0);
      wr(REG_INT_CLEAR, 32'h2);
      rd(REG_INT_STATUS, 32'h0);
      cmdRun({8'h00, 8'haf, 8'h11, OP_INIT_PARAMS});
      geo(16'h10, 16'h11);
      cmdRun({8'h00, 8'ha5, 8'h00, OP_INIT_PARAMS});
      geo(16'h6, 16'h0);
      wr(REG_CMD, 32'h01000000);
      geo(16'h6, 16'h0);
      revertOnReset <= 1'b1;
      wr(REG_CMD, 32'h01000000);
      geo(16'h10, 16'h3f);
      cmp({16'h0, idCylinders}, {16'h0, CYL});
      spindleAtSpeed <= 1'b0;
      spinSeen = 1'b0;
      wr(REG_CMD, {8'h00, DH_FIXED, 8'h00, OP_IDLE_IMM});
      repeat (8) @(posedge clk);
      rd(REG_STATUS, 32'h10080);
      wr(REG_CMD, {8'h00, DH_FIXED, 8'h00, 8'h42});
      spindleAtSpeed <= 1'b1;
      waitDone();
      rd(REG_STATUS, 32'h50);
      cmp({31'h0, spinSeen}, 32'h1);
      spinSeen = 1'b0;
      cmdRun({8'h00, DH_FIXED, 8'h00, OP_IDLE});
      repeat (100) @(posedge clk);
      cmp({30'h0, idleMode, standbyMode}, 32'h2);
      cmp({31'h0, spinSeen}, 32'h0);
      cmdRun({8'h00, DH_FIXED, 8'h08, OP_IDLE});
      repeat (50) @(posedge clk);
      cmdRun({8'h00, 8'ha3, 8'h11, OP_INIT_PARAMS});
      waitStandby(40 * SEC);
      cmdRun({8'h00, DH_FIXED, 8'h00, OP_IDLE_IMM_ALT});
      cmp({30'h0, idleMode, standbyMode}, 32'h2);
      waitStandby(40 * SEC);
      for (int i = 0; i < 7; i++) begin
         cmdRun({8'h00, DH_FIXED, tp[i], (i % 2 == 1) ? OP_IDLE_ALT : OP_IDLE});
         waitStandby(ts[i] * SEC);
      end
      results();
   end
endmodule // idle_power_and_geometry_cmds_tb_top
`default_nettype wire
